// >>> inc/ecr_pkg.sv
/*
 * Constants and types of the exception cause register block.
 * Assumes a 32-bit APB register bus and one processor clock.
 */
package ecr_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CAUSE = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_EVT = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0C;
	localparam logic [7:0] OFF_RESUME = 8'h10;

	// ------------------------------------------------------------
	// Cause field positions
	// ------------------------------------------------------------
	localparam int BD_POS = 31;
	localparam int CE_LSB = 28;
	localparam int HW_LSB = 10;
	localparam int SW_LSB = 8;
	localparam int CODE_LSB = 2;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int IE_POS = 0;
	localparam int EXL_POS = 1;
	localparam int ERL_POS = 2;
	localparam int IM_LSB = 8;

	// ------------------------------------------------------------
	// Event bits
	// ------------------------------------------------------------
	localparam int EVT_EXC = 0;
	localparam int EVT_INT = 1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] CE_RST = 2'h0;
	localparam logic [1:0] SW_RST = 2'h0;
	localparam logic [4:0] CODE_RST = 5'h00;
	localparam logic [7:0] IM_RST = 8'h00;
	localparam logic ERL_RST = 1'b1;
	localparam logic [1:0] EVT_RST = 2'h0;

	// ------------------------------------------------------------
	// Exception kinds and codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		EK_INTERRUPT, EK_TLB_MOD, EK_TLB_MISS_LOAD, EK_TLB_MISS_STORE,
		EK_ADDR_ERROR_LOAD, EK_ADDR_ERROR_STORE, EK_FETCH_BUS_ERROR,
		EK_LOAD_BUS_ERROR, EK_SYSCALL, EK_BREAKPOINT_FAULT,
		EK_ILLEGAL_OPCODE, EK_COP_UNUSABLE, EK_ARITH_OVERFLOW,
		EK_TRAP_FAULT
	} ecr_kind_t;

	localparam logic [4:0] CODE_MAX = 5'h0D;
endpackage : ecr_pkg

// >>> rtl/ecr_sync.sv
/*
 * Two-flop synchroniser for the hardware interrupt pins.
 * Assumes asynchronous pins; only the second stage is read.
 */
`timescale 1ns/1ns
`default_nettype none
module ecr_sync #(
	parameter int WIDTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule : ecr_sync
`default_nettype wire

// >>> rtl/ecr_code_map.sv
/*
 * Maps the pipeline's exception kind to the five-bit code.
 * Assumes the kind is an ecr_kind_t value; others yield invalid.
 */
`timescale 1ns/1ns
`default_nettype none
module ecr_code_map (
	input wire logic [3:0] kind,
	output logic [4:0] code,
	output logic valid
);
	// Codes 14 and up are never produced
	function automatic logic [4:0] ecr_code_of(input logic [3:0] k);
		ecr_code_of = {1'b0, k};
	endfunction : ecr_code_of

	always_comb begin
		valid = ({1'b0, kind} <= ecr_pkg::CODE_MAX);
		code = valid ? ecr_code_of(kind) : ecr_pkg::CODE_RST;
	end
endmodule : ecr_code_map
`default_nettype wire

// >>> rtl/ecr_top.sv
/*
 * Exception cause register with APB access, interrupt request
 * logic and the resume address capture.
 * Assumes the pipeline pulses exc_commit for one cycle per exception
 * taken and interrupt pins are asynchronous.
 */
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ecr_top #(
	parameter int NUM_HW_INT = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_HW_INT-1:0] hw_int_pins,
	input wire logic exc_commit,
	input wire logic [3:0] exc_kind,
	input wire logic exc_in_delay_slot,
	input wire logic [1:0] exc_cop_num,
	input wire logic [31:0] exc_inst_pc,
	input wire logic [31:0] exc_branch_pc,
	output logic int_request,
	output logic irq
);
	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (NUM_HW_INT < 1 || NUM_HW_INT > 4) begin : g_bad_width
		$error("NUM_HW_INT must be 1 to 4");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic branch_delay_flag_q;
	logic [1:0] cop_num_q;
	logic [4:0] exception_code_field_q;
	logic [1:0] sw_interrupt_request_q;
	logic global_int_enable_q;
	logic exception_level_bit_q;
	logic error_level_bit_q;
	logic [7:0] interrupt_mask_field_q;
	logic [31:0] resume_address_reg_q;
	logic [1:0] evt_q;
	logic [1:0] evt_d;
	logic [1:0] evt_mask_q;
	logic [31:0] rdata_q;
	logic slverr_q;
	logic [NUM_HW_INT-1:0] hw_sync;
	logic [3:0] hw_interrupt_pending;
	logic [7:0] interrupt_pending_bits;
	logic [4:0] mapped_code;
	logic code_valid;
	logic take;
	logic setup;
	logic wr_done;
	logic rd_done;
	logic int_enabled;
	logic int_request_q;
	logic [31:0] cause_word;
	logic [31:0] ctrl_word;

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	ecr_sync #(
		.WIDTH(NUM_HW_INT)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(hw_int_pins),
		.sync_out(hw_sync)
	);

	ecr_code_map u_map (
		.kind(exc_kind),
		.code(mapped_code),
		.valid(code_valid)
	);

	// ------------------------------------------------------------
	// Bus phases
	// ------------------------------------------------------------
	// Zero wait states keeps the access phase one cycle long
	assign pready = 1'b1;
	assign setup = psel && !penable;
	assign wr_done = psel && penable && pwrite;
	assign rd_done = psel && penable && !pwrite;
	// Unknown kinds are dropped rather than recorded as a bad code
	assign take = exc_commit && code_valid;

	// ------------------------------------------------------------
	// Cause fields written by hardware
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch_delay_flag_q <= 1'b0;
			cop_num_q <= ecr_pkg::CE_RST;
			exception_code_field_q <= ecr_pkg::CODE_RST;
		end else if (take) begin
			branch_delay_flag_q <= exc_in_delay_slot;
			cop_num_q <= exc_cop_num;
			exception_code_field_q <= mapped_code;
		end
	end

	// ------------------------------------------------------------
	// Software interrupt requests
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_interrupt_request_q <= ecr_pkg::SW_RST;
		end else if (wr_done && paddr == ecr_pkg::OFF_CAUSE) begin
			sw_interrupt_request_q <= pwdata[ecr_pkg::SW_LSB +: 2];
		end
	end

	// Pending lines track the synchronised pins, no storage
	always_comb begin
		hw_interrupt_pending = '0;
		hw_interrupt_pending[NUM_HW_INT-1:0] = hw_sync;
		interrupt_pending_bits = {2'b00, hw_interrupt_pending,
			sw_interrupt_request_q};
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Hardware raising the exception level wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_int_enable_q <= 1'b0;
			exception_level_bit_q <= 1'b0;
			error_level_bit_q <= ecr_pkg::ERL_RST;
			interrupt_mask_field_q <= ecr_pkg::IM_RST;
		end else begin
			if (wr_done && paddr == ecr_pkg::OFF_CTRL) begin
				global_int_enable_q <= pwdata[ecr_pkg::IE_POS];
				exception_level_bit_q <= pwdata[ecr_pkg::EXL_POS];
				error_level_bit_q <= pwdata[ecr_pkg::ERL_POS];
				interrupt_mask_field_q <= pwdata[ecr_pkg::IM_LSB +: 8];
			end
			if (take) begin
				exception_level_bit_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Resume address
	// ------------------------------------------------------------
	// Nested exceptions keep the first resume point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_address_reg_q <= '0;
		end else if (take && !exception_level_bit_q) begin
			resume_address_reg_q <= exc_in_delay_slot ? exc_branch_pc
				: exc_inst_pc;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request to the pipeline
	// ------------------------------------------------------------
	assign int_enabled = global_int_enable_q && !exception_level_bit_q
		&& !error_level_bit_q;
	assign int_request = int_enabled
		&& |(interrupt_pending_bits & interrupt_mask_field_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_request_q <= 1'b0;
		end else begin
			int_request_q <= int_request;
		end
	end

	// ------------------------------------------------------------
	// Event status, mask and irq
	// ------------------------------------------------------------
	always_comb begin
		evt_d = evt_q;
		// Clear only what the read reported, so a late set survives
		if (rd_done && paddr == ecr_pkg::OFF_EVT) begin
			evt_d = evt_q & ~rdata_q[1:0];
		end
		// Set wins over the read clear
		if (take) begin
			evt_d[ecr_pkg::EVT_EXC] = 1'b1;
		end
		if (int_request && !int_request_q) begin
			evt_d[ecr_pkg::EVT_INT] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= ecr_pkg::EVT_RST;
		end else begin
			evt_q <= evt_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_mask_q <= ecr_pkg::EVT_RST;
		end else if (wr_done && paddr == ecr_pkg::OFF_MASK) begin
			evt_mask_q <= pwdata[1:0];
		end
	end

	assign irq = |(evt_q & evt_mask_q);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		cause_word = '0;
		cause_word[ecr_pkg::BD_POS] = branch_delay_flag_q;
		cause_word[ecr_pkg::CE_LSB +: 2] = cop_num_q;
		cause_word[ecr_pkg::SW_LSB +: 8] = interrupt_pending_bits;
		cause_word[ecr_pkg::CODE_LSB +: 5] = exception_code_field_q;
		ctrl_word = '0;
		ctrl_word[ecr_pkg::IE_POS] = global_int_enable_q;
		ctrl_word[ecr_pkg::EXL_POS] = exception_level_bit_q;
		ctrl_word[ecr_pkg::ERL_POS] = error_level_bit_q;
		ctrl_word[ecr_pkg::IM_LSB +: 8] = interrupt_mask_field_q;
	end

	// Read data is captured at setup so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
			slverr_q <= 1'b0;
		end else if (setup) begin
			slverr_q <= 1'b0;
			if (paddr == ecr_pkg::OFF_CAUSE) begin
				rdata_q <= cause_word;
			end else if (paddr == ecr_pkg::OFF_CTRL) begin
				rdata_q <= ctrl_word;
			end else if (paddr == ecr_pkg::OFF_EVT) begin
				rdata_q <= {30'h0, evt_q};
			end else if (paddr == ecr_pkg::OFF_MASK) begin
				rdata_q <= {30'h0, evt_mask_q};
			end else if (paddr == ecr_pkg::OFF_RESUME) begin
				rdata_q <= resume_address_reg_q;
			end else begin
				rdata_q <= '0;
				slverr_q <= 1'b1;
			end
		end
	end

	assign prdata = rdata_q;
	assign pslverr = slverr_q && psel && penable;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_cause_load: assert property (take |=>
		exception_code_field_q == $past(mapped_code))
		else $error("cause code not loaded");
	a_hw_only_fields: assert property (!take |=>
		$stable(exception_code_field_q) && $stable(cop_num_q))
		else $error("hardware field changed without exception");
	a_bd_flag: assert property (take |=>
		branch_delay_flag_q == $past(exc_in_delay_slot))
		else $error("delay flag wrong");
	a_cop_num: assert property (take |=>
		cop_num_q == $past(exc_cop_num))
		else $error("coprocessor number wrong");
	a_hw_pending: assert property (##2 1'b1 |->
		hw_interrupt_pending[NUM_HW_INT-1:0] == $past(hw_int_pins, 2))
		else $error("pending lines do not follow pins");
	a_sw_write: assert property (wr_done && paddr == ecr_pkg::OFF_CAUSE
		|=> sw_interrupt_request_q == $past(pwdata[9:8]))
		else $error("software request not written");
	a_code_range: assert property (
		exception_code_field_q <= ecr_pkg::CODE_MAX)
		else $error("exception code out of range");
	a_code_ident: assert property (take |=>
		exception_code_field_q == {1'b0, $past(exc_kind)})
		else $error("code does not match kind");
	a_no_bad_code: assert property (exc_commit && !code_valid |=>
		$stable(exception_code_field_q))
		else $error("invalid kind recorded");
	a_reserved_zero: assert property (rd_done && paddr == ecr_pkg::OFF_CAUSE
		|-> (prdata & 32'h4FFF_C083) == 32'h0000_0000)
		else $error("reserved cause bit set");
	a_atomic_update: assert property ($changed(branch_delay_flag_q)
		|-> $past(take))
		else $error("delay flag changed alone");
	a_int_gate: assert property (int_request |->
		|(interrupt_pending_bits & interrupt_mask_field_q))
		else $error("interrupt without pending masked bit");
	a_int_enable: assert property (exception_level_bit_q
		|| error_level_bit_q || !global_int_enable_q |-> !int_request)
		else $error("interrupt while disabled");
	a_resume_branch: assert property (take && !exception_level_bit_q
		&& exc_in_delay_slot |=> resume_address_reg_q
		== $past(exc_branch_pc))
		else $error("resume address not at branch");

	c_delay_slot: cover property (take && exc_in_delay_slot);
	c_cop_fault: cover property (take && exc_kind == 4'h0B);
	c_int_req: cover property (int_request ##1 take);
	c_sw_int: cover property (wr_done ##1 int_request);
endmodule : ecr_top
`default_nettype wire

// >>> sim/ecr_pipe_model.sv
/*
 * Pipeline exception logic and interrupt pin model.
 * Assumes the bench calls its tasks just after a rising pclk edge.
 */
`timescale 1ns/1ns
`default_nettype none
module ecr_pipe_model (
	input wire logic pclk,
	output logic [3:0] hw_int_pins,
	output logic exc_commit,
	output logic [3:0] exc_kind,
	output logic exc_in_delay_slot,
	output logic [1:0] exc_cop_num,
	output logic [31:0] exc_inst_pc,
	output logic [31:0] exc_branch_pc
);
	// ------------------------------------------------------------
	// Stimulus tasks
	// ------------------------------------------------------------
	initial begin
		hw_int_pins = 4'h0;
		exc_commit = 1'b0;
		exc_kind = 4'h0;
		exc_in_delay_slot = 1'b0;
		exc_cop_num = 2'h0;
		exc_inst_pc = 32'h0;
		exc_branch_pc = 32'h0;
	end

	// One-cycle commit pulse; fields change with it, only the kind changes again after it
	task automatic fire(input logic [3:0] k, input logic bd,
			input logic [1:0] cop, input logic [31:0] pc);
		@(posedge pclk);
		exc_commit <= 1'b1;
		exc_kind <= k;
		exc_in_delay_slot <= bd;
		exc_cop_num <= cop;
		exc_inst_pc <= pc;
		exc_branch_pc <= pc - 32'h4;
		@(posedge pclk);
		exc_commit <= 1'b0;
		// Stale kind would hide a missing commit qualifier
		exc_kind <= ~k;
	endtask : fire

	task automatic pins(input logic [3:0] v);
		@(posedge pclk);
		hw_int_pins <= v;
	endtask : pins
endmodule : ecr_pipe_model
`default_nettype wire

// >>> sim/exception_cause_register_tb.sv
/*
 * Self-checking bench of the exception cause register.
 * Assumes ecr_top and ecr_pipe_model are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
module exception_cause_register_tb;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, ipc, exp_c;
	logic pready, pslverr, int_request, irq, exc_commit, bd;
	logic exc_in_delay_slot;
	logic [3:0] hw_int_pins, exc_kind;
	logic [1:0] exc_cop_num;
	logic [31:0] exc_inst_pc, exc_branch_pc;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	ecr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_int_pins(hw_int_pins),
		.exc_commit(exc_commit), .exc_kind(exc_kind),
		.exc_in_delay_slot(exc_in_delay_slot),
		.exc_cop_num(exc_cop_num), .exc_inst_pc(exc_inst_pc),
		.exc_branch_pc(exc_branch_pc), .int_request(int_request),
		.irq(irq));
	ecr_pipe_model i_pipe (.pclk(pclk), .hw_int_pins(hw_int_pins),
		.exc_commit(exc_commit), .exc_kind(exc_kind),
		.exc_in_delay_slot(exc_in_delay_slot),
		.exc_cop_num(exc_cop_num), .exc_inst_pc(exc_inst_pc),
		.exc_branch_pc(exc_branch_pc));

	// ------------------------------------------------------------
	// Clock, timeout and checking
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string n, input logic [31:0] s, e);
		tests_run = tests_run + 1;
		if (s !== e) begin
			mismatches = mismatches + 1;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// ------------------------------------------------------------
	// APB master
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd,
			output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rc(input string n, input logic [7:0] a,
			input logic [31:0] e, input logic [31:0] m);
		logic [31:0] r;
		logic x;
		apb(1'b0, a, 32'h0, r, x);
		chk(n, r & m, e & m);
	endtask : rc

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rc("cause", ecr_pkg::OFF_CAUSE, 32'h0, '1);
		rc("ctrl", ecr_pkg::OFF_CTRL, 32'h4, '1);
		rc("evt", ecr_pkg::OFF_EVT, 32'h0, '1);
		rc("mask", ecr_pkg::OFF_MASK, 32'h0, '1);
		chk("intreq", {31'h0, int_request}, 32'h0);
	endtask : t_reset

	// Every code once, delay flag toggling, resume address each time
	task automatic t_codes();
		for (int k = 0; k <= 13; k++) begin
			bd = k[0];
			ipc = 32'h100 + 32'(k) * 32'h10;
			wr(ecr_pkg::OFF_CTRL, 32'h0);
			i_pipe.fire(4'(k), bd, 2'(k), ipc);
			exp_c = {bd, 1'b0, 2'(k), 21'h0, 5'(k), 2'b00};
			rc("code", ecr_pkg::OFF_CAUSE, exp_c,
				(k == 11) ? 32'hFFFFFFFF : 32'hCFFFFFFF);
			rc("resume", ecr_pkg::OFF_RESUME,
				bd ? ipc - 32'h4 : ipc, '1);
		end
	endtask : t_codes

	// Kinds 14/15 leave cause untouched; software writes change only the request bits
	task automatic t_guard();
		i_pipe.fire(4'hE, 1'b0, 2'h0, 32'h0);
		i_pipe.fire(4'hF, 1'b0, 2'h1, 32'h0);
		rc("ign", ecr_pkg::OFF_CAUSE, 32'h9000_0034, '1);
		wr(ecr_pkg::OFF_CAUSE, 32'hFFFF_FFFF);
		rc("swset", ecr_pkg::OFF_CAUSE, 32'h9000_0334, '1);
		wr(ecr_pkg::OFF_CAUSE, 32'h0);
		rc("swclr", ecr_pkg::OFF_CAUSE, 32'h9000_0034, '1);
		i_pipe.pins(4'hA);
		repeat (3) @(posedge pclk);
		rc("hw", ecr_pkg::OFF_CAUSE, 32'h0000_2800, 32'h3C00);
		i_pipe.pins(4'h0);
	endtask : t_guard

	// Enable gating: only IE with no EXCEPTION_LEVEL_BIT/ERROR_LEVEL_BIT and matched mask
	task automatic t_intreq();
		wr(ecr_pkg::OFF_CAUSE, 32'h200);
		wr(ecr_pkg::OFF_CTRL, 32'h0201);
		@(negedge pclk);
		chk("ir_on", {31'h0, int_request}, 32'h1);
		wr(ecr_pkg::OFF_CTRL, 32'h0101);
		@(negedge pclk);
		chk("ir_msk", {31'h0, int_request}, 32'h0);
		wr(ecr_pkg::OFF_CTRL, 32'h0203);
		@(negedge pclk);
		chk("ir_exl", {31'h0, int_request}, 32'h0);
		wr(ecr_pkg::OFF_CTRL, 32'h0205);
		@(negedge pclk);
		chk("ir_erl", {31'h0, int_request}, 32'h0);
		rc("ev_int", ecr_pkg::OFF_EVT, 32'h2, 32'h2);
		wr(ecr_pkg::OFF_CAUSE, 32'h0);
	endtask : t_intreq

	// Interrupt: raise, clear, mask; unmapped slot
	task automatic t_irq();
		logic [31:0] r;
		logic e;
		rc("ev_clr", ecr_pkg::OFF_EVT, 32'h0, '1);
		wr(ecr_pkg::OFF_MASK, 32'h1);
		i_pipe.fire(4'h8, 1'b0, 2'h0, 32'h40);
		@(negedge pclk);
		chk("irq_on", {31'h0, irq}, 32'h1);
		rc("ev_set", ecr_pkg::OFF_EVT, 32'h1, '1);
		@(negedge pclk);
		chk("irq_off", {31'h0, irq}, 32'h0);
		wr(ecr_pkg::OFF_MASK, 32'h0);
		i_pipe.fire(4'h9, 1'b0, 2'h0, 32'h80);
		@(negedge pclk);
		chk("irq_msk", {31'h0, irq}, 32'h0);
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk("unmap", {e, r[30:0]}, 32'h8000_0000);
	endtask : t_irq

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_codes();
		t_guard();
		t_intreq();
		t_irq();
		report_and_stop();
	end
endmodule : exception_cause_register_tb
`default_nettype wire
